// ==== rtl/twt_pkg.sv ====
// ==========================================================
// register map, field layout and shared types
package twt_pkg;

	// ==========================================================
	// register byte offsets on the apb side
	localparam logic [11:0] TASKS_OFS = 12'h000;
	localparam logic [11:0] EVENTS_OFS = 12'h100;
	localparam logic [11:0] ENABLE_OFS = 12'h500;
	localparam logic [11:0] RX_PTR_OFS = 12'h534;
	localparam logic [11:0] RX_MAX_OFS = 12'h538;
	localparam logic [11:0] RX_AMT_OFS = 12'h53C;
	localparam logic [11:0] TX_PTR_OFS = 12'h544;
	localparam logic [11:0] TX_MAX_OFS = 12'h548;
	localparam logic [11:0] TX_AMT_OFS = 12'h54C;
	localparam logic [11:0] ADDRESS_OFS = 12'h588;
	localparam logic [11:0] CONFIG_OFS = 12'h594;
	localparam logic [11:0] FILL_OFS = 12'h5C0;

	// ==========================================================
	// field positions
	localparam int TASK_HALT_BIT = 0;
	localparam int TASK_ARM_RX_BIT = 1;
	localparam int TASK_ARM_TX_BIT = 2;
	localparam int EV_HALTED_BIT = 0;
	localparam int EV_RX_BEGUN_BIT = 1;
	localparam int EV_TX_BEGUN_BIT = 2;
	localparam int EV_ERROR_BIT = 3;
	localparam int EV_W = 4;
	localparam int CNT_W = 10;

	// ==========================================================
	// reset values and counts
	localparam logic [7:0] FILL_RST = 8'h00;
	localparam logic [6:0] ADDRESS_RST = 7'h00;
	localparam logic [31:0] PTR_RST = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ==========================================================
	// memory channel carriers, one byte per access
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [7:0] data;
	} twt_mem_req_type;

	typedef struct packed {
		logic ack;
		logic [7:0] data;
	} twt_mem_ans_type;

	// conditions seen on the synchronised bus lines
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} twt_line_type;

	typedef enum logic [3:0] {
		ST_OFF,
		ST_IDLE,
		ST_ADDR,
		ST_SKIP,
		ST_HOLD,
		ST_ADDR_ACK,
		ST_TX_BIT,
		ST_TX_ACK,
		ST_RX_BIT,
		ST_RX_ACK,
		ST_WAIT_END,
		ST_HALT
	} twt_state_type;

	// saturation is not needed: rx and index counts stop at the byte limit; tx_amt_r is not held there and wraps
	function automatic logic [CNT_W-1:0] twt_inc(input logic [CNT_W-1:0] v);
		twt_inc = v + 10'h001;
	endfunction

endpackage

// ==== rtl/twt_line_watch.sv ====
`timescale 1ns/1ps
// ==========================================================
// bus line synchroniser and condition detector
module twt_line_watch (
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output twt_pkg::twt_line_type line
);

	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic scl_q_r;
	logic sda_q_r;

	// two synchroniser flops and one delay flop per pin; lines idle high so reset to one
	always_ff @(posedge clk) begin
		if (!resetn) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_q_r <= '1;
			sda_q_r <= '1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], scl_pin};
			sda_sync_r <= {sda_sync_r[0], sda_pin};
			scl_q_r <= scl_sync_r[1];
			sda_q_r <= sda_sync_r[1];
		end
	end

	// start and restart look the same here; the core sends both straight to the address phase
	assign line.start = scl_sync_r[1] & scl_q_r & sda_q_r & ~sda_sync_r[1];
	assign line.stop = scl_sync_r[1] & scl_q_r & ~sda_q_r & sda_sync_r[1];
	assign line.rise = scl_sync_r[1] & ~scl_q_r;
	assign line.fall = ~scl_sync_r[1] & scl_q_r;
	assign line.sda = sda_sync_r[1];

endmodule // twt_line_watch

// ==== rtl/twt_two_wire_target.sv ====
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module twt_two_wire_target (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SCL_I,
	output logic SCL_O,
	output logic SCL_OE_N,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_N,
	output twt_pkg::twt_mem_req_type MEM_REQ,
	input twt_pkg::twt_mem_ans_type MEM_ANS,
	output logic LOW_POWER
);

	// ==========================================================
	// declarations
	twt_pkg::twt_line_type line;
	twt_pkg::twt_state_type state_r;
	logic enable_r;
	logic match_en_r;
	logic [6:0] addr_r;
	logic [7:0] fill_r;
	logic [31:0] tx_ptr_r;
	logic [31:0] rx_ptr_r;
	logic [twt_pkg::CNT_W-1:0] tx_max_r;
	logic [twt_pkg::CNT_W-1:0] rx_max_r;
	logic [twt_pkg::CNT_W-1:0] tx_amt_r;
	logic [twt_pkg::CNT_W-1:0] rx_amt_r;
	logic [twt_pkg::EV_W-1:0] events_r;
	logic [twt_pkg::EV_W-1:0] ev_set;
	logic [twt_pkg::EV_W-1:0] ev_clr;
	logic tx_prep_r;
	logic rx_prep_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic dir_r;
	logic nack_r;
	logic engaged_r;
	logic [31:0] cur_ptr_r;
	logic [twt_pkg::CNT_W-1:0] cur_max_r;
	logic [twt_pkg::CNT_W-1:0] byte_idx_r;
	logic [7:0] tx_byte_r;
	logic data_ok_r;
	logic mem_busy_r;
	twt_pkg::twt_mem_req_type req_r;
	logic scl_low_r;
	logic sda_low_r;
	logic low_power_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic apb_wr;
	logic apb_setup_rd;
	logic task_halt;
	logic task_arm_tx;
	logic task_arm_rx;
	logic addr_done;
	logic addr_hit;
	logic hold_go;
	logic begin_dir;
	logic begin_p;
	logic halted_p;
	logic over;
	logic fetch_now;
	logic tx_byte_end;
	logic rx_byte_end;
	logic tx_bit;

	// ==========================================================
	// bus line watcher
	twt_line_watch u_line_watch (
		.clk(CLK),
		.resetn(RESETN),
		.scl_pin(SCL_I),
		.sda_pin(SDA_I),
		.line(line)
	);

	// ==========================================================
	// apb decode and task strobes
	assign apb_wr = PSEL & PENABLE & PWRITE;
	assign apb_setup_rd = PSEL & ~PENABLE & ~PWRITE;
	assign task_halt = apb_wr && PADDR == twt_pkg::TASKS_OFS && PWDATA[twt_pkg::TASK_HALT_BIT];
	assign task_arm_tx = apb_wr && PADDR == twt_pkg::TASKS_OFS &&
		PWDATA[twt_pkg::TASK_ARM_TX_BIT];
	assign task_arm_rx = apb_wr && PADDR == twt_pkg::TASKS_OFS &&
		PWDATA[twt_pkg::TASK_ARM_RX_BIT];

	// ==========================================================
	// transition decisions shared by several processes
	assign addr_done = state_r == twt_pkg::ST_ADDR && line.fall && bit_cnt_r == twt_pkg::BYTE_BITS;
	assign addr_hit = match_en_r && shift_r[7:1] == addr_r;
	assign hold_go = state_r == twt_pkg::ST_HOLD && (dir_r ? tx_prep_r : rx_prep_r);
	assign begin_dir = addr_done ? shift_r[0] : dir_r;
	// begun fires when the prepared flag is present at the match, or later from hold
	assign begin_p = enable_r && !task_halt && !line.stop && !line.start &&
		((addr_done && addr_hit && (shift_r[0] ? tx_prep_r : rx_prep_r)) || hold_go);
	assign halted_p = enable_r && state_r == twt_pkg::ST_HALT && !mem_busy_r;
	assign over = byte_idx_r >= cur_max_r;
	assign fetch_now = dir_r && !data_ok_r && !mem_busy_r &&
		(state_r == twt_pkg::ST_ADDR_ACK || state_r == twt_pkg::ST_TX_BIT ||
		state_r == twt_pkg::ST_TX_ACK);
	assign tx_byte_end = state_r == twt_pkg::ST_TX_BIT && line.fall && bit_cnt_r[2:0] == twt_pkg::LAST_BIT;
	assign rx_byte_end = state_r == twt_pkg::ST_RX_BIT && line.fall && bit_cnt_r == twt_pkg::BYTE_BITS;
	assign tx_bit = tx_byte_r[twt_pkg::LAST_BIT - bit_cnt_r[2:0]];

	// event sources
	always_comb begin
		ev_set = '0;
		ev_set[twt_pkg::EV_HALTED_BIT] = halted_p;
		ev_set[twt_pkg::EV_RX_BEGUN_BIT] = begin_p && !begin_dir;
		ev_set[twt_pkg::EV_TX_BEGUN_BIT] = begin_p && begin_dir;
		ev_set[twt_pkg::EV_ERROR_BIT] = (fetch_now && over) || (rx_byte_end && over);
		ev_clr = (apb_wr && PADDR == twt_pkg::EVENTS_OFS) ? PWDATA[twt_pkg::EV_W-1:0] : '0;
	end

	// ==========================================================
	// software registers; address settings are trusted to change only while disabled
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			enable_r <= '0;
			match_en_r <= '0;
			addr_r <= twt_pkg::ADDRESS_RST;
			fill_r <= twt_pkg::FILL_RST;
			tx_ptr_r <= twt_pkg::PTR_RST;
			rx_ptr_r <= twt_pkg::PTR_RST;
			tx_max_r <= twt_pkg::CNT_RST;
			rx_max_r <= twt_pkg::CNT_RST;
		end else if (apb_wr) begin
			case (PADDR)
				twt_pkg::ENABLE_OFS: enable_r <= PWDATA[0];
				twt_pkg::CONFIG_OFS: match_en_r <= PWDATA[0];
				twt_pkg::ADDRESS_OFS: addr_r <= PWDATA[6:0];
				twt_pkg::FILL_OFS: fill_r <= PWDATA[7:0];
				twt_pkg::TX_PTR_OFS: tx_ptr_r <= PWDATA;
				twt_pkg::RX_PTR_OFS: rx_ptr_r <= PWDATA;
				twt_pkg::TX_MAX_OFS: tx_max_r <= PWDATA[twt_pkg::CNT_W-1:0];
				twt_pkg::RX_MAX_OFS: rx_max_r <= PWDATA[twt_pkg::CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// sticky events, write one to clear; a new event beats its own clear
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			events_r <= '0;
		end else begin
			events_r <= (events_r & ~ev_clr) | ev_set;
		end
	end

	// read data captured in the setup cycle so the access cycle needs no wait
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= '0;
		end else if (apb_setup_rd) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= '0;
			case (PADDR)
				twt_pkg::TASKS_OFS: ;
				twt_pkg::EVENTS_OFS: prdata_r[twt_pkg::EV_W-1:0] <= events_r;
				twt_pkg::ENABLE_OFS: prdata_r[0] <= enable_r;
				twt_pkg::CONFIG_OFS: prdata_r[0] <= match_en_r;
				twt_pkg::ADDRESS_OFS: prdata_r[6:0] <= addr_r;
				twt_pkg::FILL_OFS: prdata_r[7:0] <= fill_r;
				twt_pkg::TX_PTR_OFS: prdata_r <= tx_ptr_r;
				twt_pkg::RX_PTR_OFS: prdata_r <= rx_ptr_r;
				twt_pkg::TX_MAX_OFS: prdata_r[twt_pkg::CNT_W-1:0] <= tx_max_r;
				twt_pkg::RX_MAX_OFS: prdata_r[twt_pkg::CNT_W-1:0] <= rx_max_r;
				twt_pkg::TX_AMT_OFS: prdata_r[twt_pkg::CNT_W-1:0] <= tx_amt_r;
				twt_pkg::RX_AMT_OFS: prdata_r[twt_pkg::CNT_W-1:0] <= rx_amt_r;
				default: pslverr_r <= '1;
			endcase
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = '1;
	// the flag lingers after an unmapped read, so a later write must not show it
	assign PSLVERR = PSEL & PENABLE & ~PWRITE & pslverr_r;

	// ==========================================================
	// hidden prepared flags; unprepare wins over a simultaneous arm
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			tx_prep_r <= '0;
			rx_prep_r <= '0;
		end else begin
			if ((begin_p && begin_dir) || (halted_p && dir_r)) begin
				tx_prep_r <= '0;
			end else if (task_arm_tx) begin
				tx_prep_r <= '1;
			end
			if ((begin_p && !begin_dir) || (halted_p && !dir_r)) begin
				rx_prep_r <= '0;
			end else if (task_arm_rx) begin
				rx_prep_r <= '1;
			end
		end
	end

	// ==========================================================
	// bus state machine; bit steps move only on sampled scl edges, so a held-low clock just waits
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			state_r <= twt_pkg::ST_OFF;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			dir_r <= '0;
			nack_r <= '0;
			engaged_r <= '0;
			tx_amt_r <= twt_pkg::CNT_RST;
			rx_amt_r <= twt_pkg::CNT_RST;
		end else if (!enable_r) begin
			state_r <= twt_pkg::ST_OFF;
			engaged_r <= '0;
		end else if (state_r == twt_pkg::ST_OFF) begin
			state_r <= twt_pkg::ST_IDLE;
		end else if (task_halt) begin
			state_r <= twt_pkg::ST_HALT;
		end else if (line.stop) begin
			state_r <= engaged_r ? twt_pkg::ST_HALT : twt_pkg::ST_IDLE;
		end else if (line.start) begin
			// a restart goes straight to the address phase without passing through idle
			state_r <= twt_pkg::ST_ADDR;
			bit_cnt_r <= 4'h0;
		end else begin
			case (state_r)
				twt_pkg::ST_ADDR: begin
					if (line.rise) begin
						shift_r <= {shift_r[6:0], line.sda};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (addr_done) begin
						if (addr_hit) begin
							dir_r <= shift_r[0];
							engaged_r <= '1;
							state_r <= begin_p ? twt_pkg::ST_ADDR_ACK : twt_pkg::ST_HOLD;
						end else begin
							state_r <= twt_pkg::ST_SKIP;
						end
					end
				end
				twt_pkg::ST_HOLD: begin
					if (hold_go) begin
						state_r <= twt_pkg::ST_ADDR_ACK;
					end
				end
				twt_pkg::ST_ADDR_ACK: begin
					if (line.fall) begin
						bit_cnt_r <= 4'h0;
						state_r <= dir_r ? twt_pkg::ST_TX_BIT : twt_pkg::ST_RX_BIT;
					end
				end
				twt_pkg::ST_TX_BIT: begin
					if (tx_byte_end) begin
						tx_amt_r <= twt_pkg::twt_inc(tx_amt_r);
						state_r <= twt_pkg::ST_TX_ACK;
					end else if (line.fall) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
				end
				twt_pkg::ST_TX_ACK: begin
					if (line.rise) begin
						nack_r <= line.sda;
					end else if (line.fall) begin
						bit_cnt_r <= 4'h0;
						state_r <= nack_r ? twt_pkg::ST_WAIT_END : twt_pkg::ST_TX_BIT;
					end
				end
				twt_pkg::ST_RX_BIT: begin
					if (line.rise) begin
						shift_r <= {shift_r[6:0], line.sda};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (rx_byte_end) begin
						nack_r <= over;
						if (!over) begin
							rx_amt_r <= twt_pkg::twt_inc(rx_amt_r);
						end
						state_r <= twt_pkg::ST_RX_ACK;
					end
				end
				twt_pkg::ST_RX_ACK: begin
					if (line.fall) begin
						bit_cnt_r <= 4'h0;
						state_r <= twt_pkg::ST_RX_BIT;
					end
				end
				twt_pkg::ST_HALT: begin
					if (halted_p) begin
						engaged_r <= '0;
						state_r <= twt_pkg::ST_IDLE;
					end
				end
				default: ;
			endcase
			// amounts restart with each new transaction
			if (begin_p) begin
				tx_amt_r <= twt_pkg::CNT_RST;
				rx_amt_r <= twt_pkg::CNT_RST;
			end
		end
	end

	// ==========================================================
	// memory channels: reads feed transmit, writes take received bytes
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			req_r <= '0;
			mem_busy_r <= '0;
			data_ok_r <= '0;
			tx_byte_r <= 8'h00;
			cur_ptr_r <= twt_pkg::PTR_RST;
			cur_max_r <= twt_pkg::CNT_RST;
			byte_idx_r <= twt_pkg::CNT_RST;
		end else begin
			if (mem_busy_r && MEM_ANS.ack) begin
				req_r.valid <= '0;
				mem_busy_r <= '0;
				if (!req_r.write) begin
					tx_byte_r <= MEM_ANS.data;
					data_ok_r <= '1;
				end
			end
			if (begin_p) begin
				// pointer and limit are latched at begun so software may reload them
				cur_ptr_r <= begin_dir ? tx_ptr_r : rx_ptr_r;
				cur_max_r <= begin_dir ? tx_max_r : rx_max_r;
				byte_idx_r <= twt_pkg::CNT_RST;
				data_ok_r <= '0;
			end else if (fetch_now && over) begin
				tx_byte_r <= fill_r;
				data_ok_r <= '1;
			end else if (fetch_now) begin
				req_r <= '{valid: '1, write: '0, addr: cur_ptr_r + {22'h00_0000, byte_idx_r},
					data: 8'h00};
				mem_busy_r <= '1;
				byte_idx_r <= twt_pkg::twt_inc(byte_idx_r);
			end else if (rx_byte_end && !over) begin
				req_r <= '{valid: '1, write: '1, addr: cur_ptr_r + {22'h00_0000, byte_idx_r},
					data: shift_r};
				mem_busy_r <= '1;
				byte_idx_r <= twt_pkg::twt_inc(byte_idx_r);
			end
			if (tx_byte_end) begin
				data_ok_r <= '0;
			end
		end
	end

	assign MEM_REQ = req_r;

	// ==========================================================
	// pin drivers; stretching only starts while scl is already low
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			scl_low_r <= '0;
			sda_low_r <= '0;
			low_power_r <= '0;
		end else begin
			scl_low_r <= enable_r && (state_r == twt_pkg::ST_HOLD ||
				(state_r == twt_pkg::ST_TX_BIT && !data_ok_r) ||
				(state_r == twt_pkg::ST_RX_ACK && mem_busy_r));
			sda_low_r <= enable_r && (state_r == twt_pkg::ST_ADDR_ACK ||
				(state_r == twt_pkg::ST_TX_BIT && data_ok_r && !tx_bit) ||
				(state_r == twt_pkg::ST_RX_ACK && !nack_r));
			// no clocked work is pending while unaddressed, so the clock may be gated
			low_power_r <= state_r == twt_pkg::ST_IDLE || state_r == twt_pkg::ST_SKIP;
		end
	end

	assign SCL_O = '0;
	assign SCL_OE_N = ~scl_low_r;
	assign SDA_O = '0;
	assign SDA_OE_N = ~sda_low_r;
	assign LOW_POWER = low_power_r;

endmodule // twt_two_wire_target

// ==== tb/twt_asserts.sv ====
`timescale 1ns/1ps
// ==========================================================
// port-level checks of the two-wire target
module twt_asserts (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic SCL_I,
	input wire logic SDA_I,
	input wire logic SCL_O,
	input wire logic SDA_O,
	input wire logic SCL_OE_N,
	input wire logic SDA_OE_N,
	input twt_pkg::twt_mem_req_type MEM_REQ,
	input twt_pkg::twt_mem_ans_type MEM_ANS,
	input wire logic LOW_POWER
);
	logic busy_r;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	// ==========================================================
	// set once the target has driven data, cleared back in low power
	always_ff @(posedge CLK) begin
		if (!RESETN || LOW_POWER) begin
			busy_r <= 1'b0;
		end else if (!SDA_OE_N) begin
			busy_r <= 1'b1;
		end
	end
	// ==========================================================
	// register bus
	ready_a: assert property (PSEL && PENABLE |-> PREADY)
		else $error("no ready in access phase");
	slverr_a: assert property (PSLVERR |-> PSEL && PENABLE && !PWRITE)
		else $error("error flag outside a read access");
	// ==========================================================
	// memory channel holds its request until answered
	mem_hold_a: assert property (MEM_REQ.valid && !MEM_ANS.ack |=> $stable(MEM_REQ))
		else $error("memory request changed before ack");
	// ==========================================================
	// bus lines; one cycle of lag is allowed when low power ends
	quiet_a: assert property (LOW_POWER && $past(LOW_POWER) |->
		$past(SDA_OE_N) && $past(SCL_OE_N) && !$past(MEM_REQ.valid))
		else $error("activity while in low power");
	sda_edge_a: assert property ($changed(SDA_OE_N) |-> !$past(SCL_I))
		else $error("data line moved while clock high");
	scl_grab_a: assert property ($fell(SCL_OE_N) |-> !$past(SCL_I))
		else $error("clock pulled low while high");
	drive_zero_a: assert property (!SCL_OE_N || !SDA_OE_N |-> !SCL_O && !SDA_O)
		else $error("open drain output drives high");
	// the bound covers a slow memory answer before the halt completes
	stop_idle_a: assert property (busy_r && SCL_I && $past(SCL_I) && $rose(SDA_I)
		|-> ##[1:300] LOW_POWER)
		else $error("no return to idle after stop");
endmodule // twt_asserts

// ==== tb/twt_ctl_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// bus controller model, the only controller on the bus
module twt_ctl_model (
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe_n,
	output logic sda_oe_n
);
	// quarter of the 125 ns bus clock period
	localparam realtime QTR = 31.25;
	// extra low time per bit: the controller stretching its own clock
	realtime slow = 0.0;
	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
	end
	// release the clock; the target may still hold it low
	task automatic scl_up();
		scl_oe_n = 1'b1;
		wait (scl === 1'b1);
	endtask
	// one bit each way, data changed only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_oe_n = b;
		#(QTR + slow);
		scl_up();
		#QTR r = sda;
		#QTR scl_oe_n = 1'b0;
		#QTR;
	endtask
	// also serves as a repeated start
	task automatic start();
		sda_oe_n = 1'b1;
		#QTR;
		scl_up();
		#QTR sda_oe_n = 1'b0;
		#(2 * QTR) scl_oe_n = 1'b0;
		#QTR;
	endtask
	task automatic stop();
		sda_oe_n = 1'b0;
		#QTR;
		scl_up();
		#QTR sda_oe_n = 1'b1;
		#(4 * QTR);
	endtask
	// byte msb first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ack_in, ack);
	endtask
endmodule // twt_ctl_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================
// top-level bench of the two-wire target
module tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic t_scl_oe_n;
	logic t_sda_oe_n;
	logic c_scl_oe_n;
	logic c_sda_oe_n;
	logic low_power;
	logic [2:0] mcnt = 3'h0;
	logic [7:0] ram [256];
	twt_pkg::twt_mem_req_type mem_req;
	twt_pkg::twt_mem_ans_type mem_ans = '0;
	int err_count = 0;
	int comparisons = 0;
	// wired-and lines with pull-ups
	wire logic scl = t_scl_oe_n & c_scl_oe_n;
	wire logic sda = t_sda_oe_n & c_sda_oe_n;

	twt_two_wire_target twt_two_wire_target_i (.CLK(clk), .RESETN(resetn), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SCL_I(scl), .SCL_O(), .SCL_OE_N(t_scl_oe_n),
		.SDA_I(sda), .SDA_O(), .SDA_OE_N(t_sda_oe_n), .MEM_REQ(mem_req), .MEM_ANS(mem_ans),
		.LOW_POWER(low_power));
	twt_ctl_model twt_ctl_model_i (.scl(scl), .sda(sda), .scl_oe_n(c_scl_oe_n),
		.sda_oe_n(c_sda_oe_n));

	initial begin
		forever #2.5 clk = ~clk;
	end
	// ==========================================================
	// ram with a fixed answer delay; data wanders when not valid
	always @(posedge clk) begin
		mem_ans.ack <= 1'b0;
		mem_ans.data <= ~mem_ans.data;
		if (mem_req.valid && !mem_ans.ack) begin
			mcnt <= mcnt + 3'h1;
			if (mcnt == 3'h3) begin
				mcnt <= 3'h0;
				mem_ans.ack <= 1'b1;
				if (mem_req.write) begin
					ram[mem_req.addr[7:0]] <= mem_req.data;
				end else begin
					mem_ans.data <= ram[mem_req.addr[7:0]];
				end
			end
		end
	end
	// ==========================================================
	// checks and bus tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		logic r;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// answer is taken at the very edge at which ready is seen high
		do begin
			@(posedge clk);
			r = pready;
			q = prdata;
			e = pslverr;
		end while (r !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, '0, q, e);
		chk(q, x);
	endtask
	// poll until the halt shows up, compare, then clear all events
	task automatic ev(input logic [31:0] x);
		logic [31:0] q;
		logic e;
		q = '0;
		for (int i = 0; i < 50 && q[0] !== 1'b1; i++) apb(1'b0, twt_pkg::EVENTS_OFS, '0, q, e);
		chk(q, x);
		wr(twt_pkg::EVENTS_OFS, 32'h0000_000F);
	endtask
	task automatic addr(input logic rdb, input logic [31:0] x);
		logic [7:0] q;
		logic k;
		twt_ctl_model_i.start();
		twt_ctl_model_i.xfer({7'h2A, rdb}, 1'b1, q, k);
		chk({31'h0, k}, x);
	endtask
	// address while unprepared: the clock must be held until the task
	task automatic stretched(input logic rdb, input logic [31:0] task_bits);
		fork
			addr(rdb, 32'h0);
			begin
				repeat (400) @(posedge clk);
				chk({31'h0, t_scl_oe_n}, 32'h0);
				wr(twt_pkg::TASKS_OFS, task_bits);
			end
		join
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ==========================================================
	// watchdog, well beyond the expected run of about 5600 cycles
	initial begin
		repeat (80000) @(posedge clk);
		err_count++;
		stop_test();
	end
	// ==========================================================
	// test sequence
	initial begin
		static logic [11:0] ofs [8] = '{twt_pkg::ENABLE_OFS, twt_pkg::RX_MAX_OFS,
			twt_pkg::RX_AMT_OFS,
			twt_pkg::TX_AMT_OFS, twt_pkg::ADDRESS_OFS, twt_pkg::CONFIG_OFS, twt_pkg::FILL_OFS,
			twt_pkg::EVENTS_OFS};
		static logic [7:0] txb [3] = '{8'hC3, 8'h5A, 8'hA5};
		logic [31:0] d;
		logic [7:0] q;
		logic e;
		logic k;
		foreach (ram[i]) ram[i] = 8'h00;
		ram[8'h40] = txb[0];
		ram[8'h41] = txb[1];
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
		apb(1'b0, 12'hFF0, '0, d, e);
		chk({31'h0, e}, 32'h0000_0001);
		chk(d, 32'h0000_0000);
		$display("test reset values done");
		// settings go in while the target is still disabled
		wr(twt_pkg::ADDRESS_OFS, 32'h0000_002A);
		wr(twt_pkg::CONFIG_OFS, 32'h0000_0001);
		wr(twt_pkg::FILL_OFS, 32'h0000_00A5);
		wr(twt_pkg::RX_PTR_OFS, 32'h0000_0080);
		wr(twt_pkg::RX_MAX_OFS, 32'h0000_0002);
		wr(twt_pkg::TX_PTR_OFS, 32'h0000_0040);
		wr(twt_pkg::TX_MAX_OFS, 32'h0000_0002);
		addr(1'b0, 32'h0000_0001);
		twt_ctl_model_i.stop();
		$display("test disabled done");
		wr(twt_pkg::ENABLE_OFS, 32'h0000_0001);
		stretched(1'b0, 32'h0000_0002);
		twt_ctl_model_i.slow = 300.0;
		for (int i = 0; i < 3; i++) begin
			twt_ctl_model_i.xfer(8'(8'h11 * (i + 1)), 1'b1, q, k);
			chk({31'h0, k}, 32'(i == 2));
		end
		twt_ctl_model_i.stop();
		twt_ctl_model_i.slow = 0.0;
		ev(32'h0000_000B);
		chk({24'h0, ram[8'h80]}, 32'h0000_0011);
		chk({24'h0, ram[8'h81]}, 32'h0000_0022);
		chk({24'h0, ram[8'h82]}, 32'h0000_0000);
		$display("test receive done");
		wr(twt_pkg::TASKS_OFS, 32'h0000_0004);
		addr(1'b1, 32'h0);
		for (int i = 0; i < 3; i++) begin
			twt_ctl_model_i.xfer(8'hFF, 1'(i == 2), q, k);
			chk({24'h0, q}, {24'h0, txb[i]});
		end
		twt_ctl_model_i.stop();
		ev(32'h0000_000D);
		rd(twt_pkg::TX_AMT_OFS, 32'h0000_0003);
		$display("test transmit done");
		// halt and prepare in one write: the flag must end up cleared
		wr(twt_pkg::TASKS_OFS, 32'h0000_0005);
		ev(32'h0000_0001);
		stretched(1'b1, 32'h0000_0004);
		twt_ctl_model_i.xfer(8'hFF, 1'b1, q, k);
		chk({24'h0, q}, 32'h0000_00C3);
		wr(twt_pkg::TASKS_OFS, 32'h0000_0002);
		addr(1'b0, 32'h0);
		twt_ctl_model_i.xfer(8'h44, 1'b1, q, k);
		chk({31'h0, k}, 32'h0);
		twt_ctl_model_i.stop();
		ev(32'h0000_0007);
		chk({24'h0, ram[8'h80]}, 32'h0000_0044);
		$display("test halt and restart done");
		twt_ctl_model_i.start();
		twt_ctl_model_i.xfer(8'h22, 1'b1, q, k);
		chk({31'h0, k}, 32'h0000_0001);
		chk({31'h0, low_power}, 32'h0000_0001);
		twt_ctl_model_i.stop();
		$display("test foreign address done");
		stop_test();
	end
endmodule // tb_top

bind twt_two_wire_target twt_asserts twt_asserts_i (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_I(SCL_I),
	.SDA_I(SDA_I), .SCL_O(SCL_O), .SDA_O(SDA_O), .SCL_OE_N(SCL_OE_N), .SDA_OE_N(SDA_OE_N),
	.MEM_REQ(MEM_REQ), .MEM_ANS(MEM_ANS), .LOW_POWER(LOW_POWER));
